// *** design/tls_torque_limit_selector.sv ***
// torque limit selector: effective forward/reverse limits, status pin, voltage drop handling
// assumes ref_clk 100 MHz, synchronous active-low reset, AXI4-Lite master, a control-cycle tick
// Notes on behaviour
// - forward and reverse internal limits cap torque, 0..350 percent, default 300
// - any limit above the motor maximum is clamped to the motor maximum
// - forward input active: forward limit is min of internal and external forward
// - forward input inactive: forward limit is the forward external setting
// - reverse input active: reverse limit is min of internal and external reverse
// - reverse input inactive: reverse limit is the reverse external setting
// - external settings 0..350 percent, default 100, effective at once
// - limit inputs come from pins chosen by the input allocation settings
// - status pin high while output torque is being limited
// - positive and negative limit objects from the fieldbus also limit torque
// - bus voltage at or below threshold raises warning and limits current
// - during voltage drop, limit is sag percent of the internal limit
// - reduced limit persists for the release time after the warning clears
// - supply interruption shorter than hold time cycles does not stop the motor
// - slow ramp option slows bus voltage decay during undervoltage
// - servo-off command removes motor power at once
// - input allocation code 3 is forward limit, code 4 is reverse limit
// - output allocation code 3 is the torque limiting status
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tls_defs.svh"

module tls_torque_limit_selector #(
	parameter int MS_CYCLES = `TLS_MS_NS / `TLS_CLK_PERIOD_NS
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [`TLS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`TLS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [`TLS_NUM_IN_PINS-1:0] inPins,
	output logic [`TLS_NUM_OUT_PINS-1:0] outPins,
	input wire logic controlTick,
	input wire logic [`TLS_LIM_W-1:0] motorMaxTorque,
	input wire logic signed [15:0] torqueCmd,
	input wire logic [`TLS_VOLT_W-1:0] busVoltage,
	input wire logic mainPowerLost,
	output logic signed [15:0] torqueRef,
	output logic [`TLS_LIM_W-1:0] fwdLimitEff,
	output logic [`TLS_LIM_W-1:0] revLimitEff,
	output logic undervoltageWarning,
	output logic currentLimitActive,
	output logic slowBusRamp,
	output logic motorPowerEnable
);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	function automatic logic [15:0] resetValue(input logic [3:0] idx);
		case (idx)
			`TLS_IDX_FWD_INT, `TLS_IDX_REV_INT: resetValue = `TLS_INT_RESET;
			`TLS_IDX_FWD_EXT, `TLS_IDX_REV_EXT: resetValue = `TLS_EXT_RESET;
			`TLS_IDX_SAG_PCT: resetValue = `TLS_PCT_RESET;
			`TLS_IDX_SAG_REL: resetValue = `TLS_REL_RESET;
			`TLS_IDX_HOLD: resetValue = `TLS_HOLD_RESET;
			`TLS_IDX_IN_ALLOC_A: resetValue = `TLS_IN_A_RESET;
			`TLS_IDX_IN_ALLOC_B: resetValue = `TLS_IN_B_RESET;
			`TLS_IDX_OUT_ALLOC: resetValue = `TLS_OUT_RESET;
			`TLS_IDX_POS_OBJ, `TLS_IDX_NEG_OBJ: resetValue = `TLS_LIM_MAX;
			`TLS_IDX_UV_THRESH: resetValue = `TLS_UV_RESET;
			default: resetValue = 16'h0000;
		endcase
	endfunction : resetValue

	// saturates a written value to the field's range; control, allocation B, output allocation and threshold are masked instead
	function automatic logic [15:0] fieldMax(input logic [3:0] idx);
		case (idx)
			`TLS_IDX_CTRL: fieldMax = 16'h0003;
			`TLS_IDX_FWD_INT, `TLS_IDX_REV_INT, `TLS_IDX_FWD_EXT, `TLS_IDX_REV_EXT,
			`TLS_IDX_POS_OBJ, `TLS_IDX_NEG_OBJ: fieldMax = `TLS_LIM_MAX;
			`TLS_IDX_SAG_PCT: fieldMax = `TLS_PCT_MAX;
			`TLS_IDX_SAG_REL: fieldMax = `TLS_REL_MAX;
			`TLS_IDX_HOLD: fieldMax = `TLS_HOLD_MAX;
			`TLS_IDX_IN_ALLOC_B: fieldMax = 16'h000F;
			`TLS_IDX_OUT_ALLOC: fieldMax = 16'h0FFF;
			`TLS_IDX_UV_THRESH: fieldMax = 16'h0FFF;
			default: fieldMax = 16'hFFFF;
		endcase
	endfunction : fieldMax

	function automatic logic [15:0] fitField(input logic [3:0] idx, input logic [15:0] value);
		logic [15:0] lim;
		lim = fieldMax(idx);
		if (idx == `TLS_IDX_CTRL || idx == `TLS_IDX_IN_ALLOC_B || idx == `TLS_IDX_OUT_ALLOC ||
			idx == `TLS_IDX_UV_THRESH) begin
			fitField = value & lim;
		end else begin
			fitField = (value > lim) ? lim : value;
		end
	endfunction : fitField

	// true when a pin is high whose nibble of the allocation word holds the code
	function automatic logic pinMatch(input logic [19:0] alloc, input logic [4:0] pins,
		input logic [3:0] code);
		pinMatch = 1'b0;
		for (int i = 0; i < `TLS_NUM_IN_PINS; i++) begin
			if (alloc[4*i +: 4] == code && pins[i]) begin
				pinMatch = 1'b1;
			end
		end
	endfunction : pinMatch

	function automatic logic [`TLS_LIM_W-1:0] minLim(input logic [`TLS_LIM_W-1:0] a,
		input logic [`TLS_LIM_W-1:0] b);
		minLim = (a < b) ? a : b;
	endfunction : minLim

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [`TLS_NUM_IN_PINS-1:0] pinSync;

	tls_sync2 #(.WIDTH(`TLS_NUM_IN_PINS)) uSync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.asyncIn(inPins),
		.syncOut(pinSync)
	);

	// ----------------------------------------
	// AXI4-Lite slave and register file
	// ----------------------------------------
	logic [15:0] cfg_reg [`TLS_NUM_RW];
	logic [15:0] cfg_next [`TLS_NUM_RW];
	logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
	logic [3:0] awIdx_reg, awIdx_next;
	logic awMapped_reg, awMapped_next;
	logic [15:0] wData_reg, wData_next;
	logic [1:0] wStrb_reg, wStrb_next;
	logic bValid_reg, bValid_next, rValid_reg, rValid_next;
	logic [1:0] bResp_reg, bResp_next, rResp_reg, rResp_next;
	logic [31:0] rData_reg, rData_next;
	logic wrFire, tripClr;
	logic [15:0] merged;
	logic [31:0] statusWord, effWord;

	assign s_axi_awready = !awHeld_reg;
	assign s_axi_wready = !wHeld_reg;
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_arready = !rValid_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rresp = rResp_reg;
	assign s_axi_rdata = rData_reg;
	assign wrFire = awHeld_reg && wHeld_reg && !bValid_reg;
	assign merged = {wStrb_reg[1] ? wData_reg[15:8] : cfg_reg[awIdx_reg][15:8],
		wStrb_reg[0] ? wData_reg[7:0] : cfg_reg[awIdx_reg][7:0]};
	assign tripClr = wrFire && awIdx_reg == `TLS_IDX_CTRL && wStrb_reg[0] && wData_reg[`TLS_CTRL_TRIP_CLR];

	always_comb begin
		awHeld_next = awHeld_reg;
		awIdx_next = awIdx_reg;
		awMapped_next = awMapped_reg;
		wHeld_next = wHeld_reg;
		wData_next = wData_reg;
		wStrb_next = wStrb_reg;
		bValid_next = bValid_reg;
		bResp_next = bResp_reg;
		rValid_next = rValid_reg;
		rResp_next = rResp_reg;
		rData_next = rData_reg;
		for (int i = 0; i < `TLS_NUM_RW; i++) begin
			cfg_next[i] = cfg_reg[i];
		end
		if (s_axi_awvalid && !awHeld_reg) begin
			awHeld_next = 1'b1;
			awIdx_next = s_axi_awaddr[5:2];
			awMapped_next = s_axi_awaddr[7:6] == 2'h0 && s_axi_awaddr[5:2] < 4'(`TLS_NUM_RW);
		end
		if (s_axi_wvalid && !wHeld_reg) begin
			wHeld_next = 1'b1;
			wData_next = s_axi_wdata[15:0];
			wStrb_next = s_axi_wstrb[1:0];
		end
		if (wrFire) begin
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
			bValid_next = 1'b1;
			bResp_next = awMapped_reg ? `TLS_RESP_OKAY : `TLS_RESP_SLVERR;
			if (awMapped_reg) begin
				cfg_next[awIdx_reg] = fitField(awIdx_reg, merged);
			end
		end
		if (bValid_reg && s_axi_bready) begin
			bValid_next = 1'b0;
		end
		if (s_axi_arvalid && !rValid_reg) begin
			rValid_next = 1'b1;
			rResp_next = (s_axi_araddr[7:6] == 2'h0) ? `TLS_RESP_OKAY : `TLS_RESP_SLVERR;
			case (s_axi_araddr[5:2])
				`TLS_IDX_STATUS: rData_next = statusWord;
				`TLS_IDX_EFF_LIMIT: rData_next = effWord;
				default: rData_next = {16'h0000, cfg_reg[s_axi_araddr[5:2]]};
			endcase
			if (s_axi_araddr[7:6] != 2'h0) begin
				rData_next = 32'h0000_0000;
			end
		end else if (rValid_reg && s_axi_rready) begin
			rValid_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			awHeld_reg <= 1'b0;
			awIdx_reg <= 4'h0;
			awMapped_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			wData_reg <= 16'h0000;
			wStrb_reg <= 2'h0;
			bValid_reg <= 1'b0;
			bResp_reg <= `TLS_RESP_OKAY;
			rValid_reg <= 1'b0;
			rResp_reg <= `TLS_RESP_OKAY;
			rData_reg <= 32'h0000_0000;
			for (int i = 0; i < `TLS_NUM_RW; i++) begin
				cfg_reg[i] <= resetValue(4'(i));
			end
		end else begin
			awHeld_reg <= awHeld_next;
			awIdx_reg <= awIdx_next;
			awMapped_reg <= awMapped_next;
			wHeld_reg <= wHeld_next;
			wData_reg <= wData_next;
			wStrb_reg <= wStrb_next;
			bValid_reg <= bValid_next;
			bResp_reg <= bResp_next;
			rValid_reg <= rValid_next;
			rResp_reg <= rResp_next;
			rData_reg <= rData_next;
			for (int i = 0; i < `TLS_NUM_RW; i++) begin
				cfg_reg[i] <= cfg_next[i];
			end
		end
	end

	// ----------------------------------------
	// voltage drop handling
	// ----------------------------------------
	tls_pkg::tls_sag_type sag_reg, sag_next;
	logic [31:0] msCnt_reg, msCnt_next;
	logic [9:0] relCnt_reg, relCnt_next;
	logic [5:0] holdCnt_reg, holdCnt_next;
	logic trip_reg, trip_next;
	logic uvNow, sagLimiting;

	assign uvNow = busVoltage <= cfg_reg[`TLS_IDX_UV_THRESH][`TLS_VOLT_W-1:0];
	assign sagLimiting = sag_reg != tls_pkg::TLS_SAG_IDLE;

	always_comb begin
		sag_next = sag_reg;
		msCnt_next = msCnt_reg;
		relCnt_next = relCnt_reg;
		holdCnt_next = holdCnt_reg;
		trip_next = trip_reg;
		case (sag_reg)
			tls_pkg::TLS_SAG_IDLE: begin
				if (uvNow) begin
					sag_next = tls_pkg::TLS_SAG_ACTIVE;
				end
			end
			tls_pkg::TLS_SAG_ACTIVE: begin
				if (!uvNow) begin
					relCnt_next = cfg_reg[`TLS_IDX_SAG_REL][9:0];
					msCnt_next = 32'h0000_0000;
					sag_next = (cfg_reg[`TLS_IDX_SAG_REL] == 16'h0000) ? tls_pkg::TLS_SAG_IDLE :
						tls_pkg::TLS_SAG_RELEASE;
				end
			end
			tls_pkg::TLS_SAG_RELEASE: begin
				if (uvNow) begin
					sag_next = tls_pkg::TLS_SAG_ACTIVE;
				end else if (msCnt_reg == 32'(MS_CYCLES - 1)) begin
					msCnt_next = 32'h0000_0000;
					relCnt_next = relCnt_reg - 10'h001;
					if (relCnt_reg == 10'h001) begin
						sag_next = tls_pkg::TLS_SAG_IDLE;
					end
				end else begin
					msCnt_next = msCnt_reg + 32'h0000_0001;
				end
			end
			default: sag_next = tls_pkg::TLS_SAG_IDLE;
		endcase
		// interruption counted in control cycles; trip only past the hold time
		if (!mainPowerLost) begin
			holdCnt_next = 6'h00;
		end else if (controlTick && holdCnt_reg != 6'h3F) begin
			holdCnt_next = holdCnt_reg + 6'h01;
		end
		if (tripClr) begin
			trip_next = 1'b0;
		end
		if (mainPowerLost && holdCnt_reg > cfg_reg[`TLS_IDX_HOLD][5:0]) begin
			trip_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sag_reg <= tls_pkg::TLS_SAG_IDLE;
			msCnt_reg <= 32'h0000_0000;
			relCnt_reg <= 10'h000;
			holdCnt_reg <= 6'h00;
			trip_reg <= 1'b0;
		end else begin
			sag_reg <= sag_next;
			msCnt_reg <= msCnt_next;
			relCnt_reg <= relCnt_next;
			holdCnt_reg <= holdCnt_next;
			trip_reg <= trip_next;
		end
	end

	// ----------------------------------------
	// effective limit selection
	// ----------------------------------------
	logic fwdPin, revPin;
	logic [`TLS_LIM_W-1:0] fwdInt, revInt, fwdExt, revExt, fwdCand, revCand;
	logic [`TLS_LIM_W-1:0] fwdSag, revSag;
	logic [`TLS_LIM_W-1:0] fwdEff_reg, fwdEff_next, revEff_reg, revEff_next;
	logic [15:0] fwdSagWide, revSagWide;
	logic limiting;
	logic signed [15:0] torqueRef_reg, torqueRef_next;
	logic limiting_reg, limiting_next;
	logic [`TLS_NUM_OUT_PINS-1:0] outPins_reg, outPins_next;
	logic signed [15:0] fwdS, revS;

	assign fwdPin = pinMatch({cfg_reg[`TLS_IDX_IN_ALLOC_B][3:0], cfg_reg[`TLS_IDX_IN_ALLOC_A]}, pinSync,
		`TLS_CODE_FWD_LIMIT);
	assign revPin = pinMatch({cfg_reg[`TLS_IDX_IN_ALLOC_B][3:0], cfg_reg[`TLS_IDX_IN_ALLOC_A]}, pinSync,
		`TLS_CODE_REV_LIMIT);
	assign fwdInt = cfg_reg[`TLS_IDX_FWD_INT][`TLS_LIM_W-1:0];
	assign revInt = cfg_reg[`TLS_IDX_REV_INT][`TLS_LIM_W-1:0];
	assign fwdExt = cfg_reg[`TLS_IDX_FWD_EXT][`TLS_LIM_W-1:0];
	assign revExt = cfg_reg[`TLS_IDX_REV_EXT][`TLS_LIM_W-1:0];
	assign fwdSagWide = 16'((32'(fwdInt) * 32'(cfg_reg[`TLS_IDX_SAG_PCT])) / 32'd100);
	assign revSagWide = 16'((32'(revInt) * 32'(cfg_reg[`TLS_IDX_SAG_PCT])) / 32'd100);
	assign fwdSag = fwdSagWide[`TLS_LIM_W-1:0];
	assign revSag = revSagWide[`TLS_LIM_W-1:0];
	assign fwdS = 16'(fwdEff_reg);
	assign revS = 16'(revEff_reg);

	always_comb begin
		fwdCand = fwdPin ? minLim(fwdInt, fwdExt) : fwdExt;
		revCand = revPin ? minLim(revInt, revExt) : revExt;
		fwdCand = minLim(fwdCand, cfg_reg[`TLS_IDX_POS_OBJ][`TLS_LIM_W-1:0]);
		revCand = minLim(revCand, cfg_reg[`TLS_IDX_NEG_OBJ][`TLS_LIM_W-1:0]);
		if (sagLimiting) begin
			fwdCand = minLim(fwdCand, fwdSag);
			revCand = minLim(revCand, revSag);
		end
		fwdCand = minLim(fwdCand, motorMaxTorque);
		revCand = minLim(revCand, motorMaxTorque);
		fwdEff_next = controlTick ? fwdCand : fwdEff_reg;
		revEff_next = controlTick ? revCand : revEff_reg;
		limiting = (torqueCmd > fwdS) || (torqueCmd < -revS);
		torqueRef_next = torqueCmd > fwdS ? fwdS : (torqueCmd < -revS ? -revS : torqueCmd);
		if (!motorPowerEnable) begin
			torqueRef_next = 16'sh0000;
			limiting = 1'b0;
		end
		limiting_next = limiting;
		for (int k = 0; k < `TLS_NUM_OUT_PINS; k++) begin
			outPins_next[k] = limiting_reg && cfg_reg[`TLS_IDX_OUT_ALLOC][4*k +: 4] == `TLS_CODE_LIMITING;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			fwdEff_reg <= `TLS_LIM_W'(`TLS_INT_RESET);
			revEff_reg <= `TLS_LIM_W'(`TLS_INT_RESET);
			torqueRef_reg <= 16'sh0000;
			limiting_reg <= 1'b0;
			outPins_reg <= '0;
		end else begin
			fwdEff_reg <= fwdEff_next;
			revEff_reg <= revEff_next;
			torqueRef_reg <= torqueRef_next;
			limiting_reg <= limiting_next;
			outPins_reg <= outPins_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign fwdLimitEff = fwdEff_reg;
	assign revLimitEff = revEff_reg;
	assign torqueRef = torqueRef_reg;
	assign outPins = outPins_reg;
	assign undervoltageWarning = sag_reg == tls_pkg::TLS_SAG_ACTIVE;
	assign currentLimitActive = sag_reg == tls_pkg::TLS_SAG_ACTIVE;
	assign slowBusRamp = cfg_reg[`TLS_IDX_CTRL][`TLS_CTRL_SLOW_RAMP] && sag_reg == tls_pkg::TLS_SAG_ACTIVE;
	assign motorPowerEnable = cfg_reg[`TLS_IDX_CTRL][`TLS_CTRL_SERVO_ON] && !trip_reg;
	assign statusWord = {24'h000000, sag_reg, trip_reg, limiting_reg, revPin, fwdPin,
		sag_reg == tls_pkg::TLS_SAG_ACTIVE, motorPowerEnable};
	assign effWord = {6'h00, revEff_reg, 6'h00, fwdEff_reg};

endmodule : tls_torque_limit_selector

`default_nettype wire

// *** design/tls_defs.svh ***
// constants of the torque limit selector: register map, field widths, reset values, timing
// assumes inclusion by bare name from every design file that needs it
`ifndef TLS_DEFS_SVH
`define TLS_DEFS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define TLS_IDX_CTRL 4'h0
`define TLS_IDX_FWD_INT 4'h1
`define TLS_IDX_REV_INT 4'h2
`define TLS_IDX_FWD_EXT 4'h3
`define TLS_IDX_REV_EXT 4'h4
`define TLS_IDX_SAG_PCT 4'h5
`define TLS_IDX_SAG_REL 4'h6
`define TLS_IDX_HOLD 4'h7
`define TLS_IDX_IN_ALLOC_A 4'h8
`define TLS_IDX_IN_ALLOC_B 4'h9
`define TLS_IDX_OUT_ALLOC 4'hA
`define TLS_IDX_POS_OBJ 4'hB
`define TLS_IDX_NEG_OBJ 4'hC
`define TLS_IDX_UV_THRESH 4'hD
`define TLS_IDX_STATUS 4'hE
`define TLS_IDX_EFF_LIMIT 4'hF
`define TLS_NUM_RW 14
`define TLS_ADDR_W 8

// ----------------------------------------
// control register bits
// ----------------------------------------
`define TLS_CTRL_SERVO_ON 0
`define TLS_CTRL_SLOW_RAMP 1
`define TLS_CTRL_TRIP_CLR 2

// ----------------------------------------
// field widths, ranges and reset values
// ----------------------------------------
`define TLS_LIM_W 10
`define TLS_LIM_MAX 16'h015E
`define TLS_INT_RESET 16'h012C
`define TLS_EXT_RESET 16'h0064
`define TLS_PCT_MAX 16'h0064
`define TLS_PCT_RESET 16'h0032
`define TLS_REL_MAX 16'h03E8
`define TLS_REL_RESET 16'h0064
`define TLS_HOLD_MAX 16'h0032
`define TLS_HOLD_RESET 16'h0001
`define TLS_IN_A_RESET 16'h3210
`define TLS_IN_B_RESET 16'h0004
`define TLS_OUT_RESET 16'h0321
`define TLS_UV_RESET 16'h0200
`define TLS_VOLT_W 12
`define TLS_NUM_IN_PINS 5
`define TLS_NUM_OUT_PINS 3

// ----------------------------------------
// allocation codes
// ----------------------------------------
`define TLS_CODE_FWD_LIMIT 4'h3
`define TLS_CODE_REV_LIMIT 4'h4
`define TLS_CODE_LIMITING 4'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define TLS_CLK_PERIOD_NS 10
`define TLS_MS_NS 1000000

`define TLS_RESP_OKAY 2'h0
`define TLS_RESP_SLVERR 2'h2

`endif

// *** design/tls_pkg.sv ***
// types shared by the torque limit selector
// assumes nothing beyond a SystemVerilog compiler
package tls_pkg;

	// ----------------------------------------
	// voltage drop limiting phases
	// ----------------------------------------
	typedef enum logic [1:0] {
		TLS_SAG_IDLE = 2'b00,
		TLS_SAG_ACTIVE = 2'b01,
		TLS_SAG_RELEASE = 2'b10
	} tls_sag_type;

endpackage : tls_pkg

// *** design/tls_sync2.sv ***
// two flip-flop synchroniser for a group of pin levels
// assumes pins are asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module tls_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : gBit
			logic stage1_reg;
			logic stage2_reg;
			always_ff @(posedge ref_clk) begin
				if (!resetn) begin
					stage1_reg <= 1'b0;
					stage2_reg <= 1'b0;
				end else begin
					stage1_reg <= asyncIn[g];
					stage2_reg <= stage1_reg;
				end
			end
			assign syncOut[g] = stage2_reg;
		end
	endgenerate

endmodule : tls_sync2

`default_nettype wire

// *** verif/tls_torque_limit_selector_properties.sv ***
// concurrent checks on the torque limit selector top ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
`include "tls_defs.svh"

module tls_limit_props #(
	parameter int MS_CYCLES = 10
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic controlTick,
	input wire logic [`TLS_LIM_W-1:0] motorMaxTorque,
	input wire logic signed [15:0] torqueCmd,
	input wire logic signed [15:0] torqueRef,
	input wire logic [`TLS_LIM_W-1:0] fwdLimitEff,
	input wire logic [`TLS_LIM_W-1:0] revLimitEff,
	input wire logic [`TLS_NUM_OUT_PINS-1:0] outPins,
	input wire logic undervoltageWarning,
	input wire logic currentLimitActive,
	input wire logic slowBusRamp,
	input wire logic motorPowerEnable
);
	logic limNow;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// request outside the present effective window
	assign limNow = torqueCmd > $signed({6'h0, fwdLimitEff}) || torqueCmd < -$signed({6'h0, revLimitEff});

	sequence offTwo;
		!motorPowerEnable ##1 !motorPowerEnable;
	endsequence

	fwd_max_clamp_a: assert property (controlTick |=> fwdLimitEff <= $past(motorMaxTorque))
		else $error("forward limit above motor maximum");
	rev_max_clamp_a: assert property (controlTick |=> revLimitEff <= $past(motorMaxTorque))
		else $error("reverse limit above motor maximum");
	fwd_tick_only_a: assert property (!$past(controlTick) |-> $stable(fwdLimitEff))
		else $error("forward limit moved without a tick");
	rev_tick_only_a: assert property (!$past(controlTick) |-> $stable(revLimitEff))
		else $error("reverse limit moved without a tick");
	status_pin_cause_a: assert property (|outPins |-> $past(limNow, 2))
		else $error("status pin high without limiting");
	torque_window_a: assert property (torqueRef <= $signed({6'h0, $past(fwdLimitEff)}) &&
		torqueRef >= -$signed({6'h0, $past(revLimitEff)}))
		else $error("torque reference outside limits");
	power_off_zero_a: assert property (offTwo |-> torqueRef == 16'sh0000)
		else $error("torque reference with motor power off");
	current_limit_a: assert property (currentLimitActive == undervoltageWarning)
		else $error("current limit differs from warning");
	slow_ramp_a: assert property (slowBusRamp |-> undervoltageWarning)
		else $error("slow ramp outside undervoltage");
endmodule : tls_limit_props

bind tls_torque_limit_selector tls_limit_props #(.MS_CYCLES(MS_CYCLES)) u_limit_props (.ref_clk, .resetn,
	.controlTick, .motorMaxTorque, .torqueCmd, .torqueRef, .fwdLimitEff, .revLimitEff, .outPins,
	.undervoltageWarning, .currentLimitActive, .slowBusRamp, .motorPowerEnable);

`default_nettype wire

// *** verif/tls_host_model.sv ***
// host side: maps the two limit requests onto connector pins
// assumes the reset input allocation (pin 3 forward, pin 4 reverse)
`timescale 1ns/100ps
`default_nettype none
`include "tls_defs.svh"

module tls_host_model (
	input wire logic fwdReq,
	input wire logic revReq,
	output logic [`TLS_NUM_IN_PINS-1:0] inPins
);
	// unused pins stay open, read as off
	assign inPins = {revReq, fwdReq, 3'b000};
endmodule : tls_host_model

`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the torque limit selector
// assumes the design files, the host model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "tls_defs.svh"

module tb;
	typedef struct packed {
		logic [9:0] intLim;
		logic [9:0] extLim;
		logic pinOn;
		logic [9:0] maxTq;
		logic [9:0] expLim;
	} tls_row_type;

	localparam int MS = 10;
	localparam int LIMIT = 5000;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
	logic controlTick = 1'b0, mainPowerLost = 1'b0, fwdReq = 1'b0, revReq = 1'b0;
	logic [9:0] motorMaxTorque = 10'h3FF;
	logic signed [15:0] torqueCmd = 16'sh0000;
	logic [11:0] busVoltage = 12'hFFF;
	wire logic [4:0] inPins;
	logic [2:0] outPins;
	logic signed [15:0] torqueRef;
	logic [9:0] fwdLimitEff, revLimitEff;
	logic undervoltageWarning, currentLimitActive, slowBusRamp, motorPowerEnable;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	logic [7:0] rstAddr [4] = '{8'h04, 8'h0C, 8'h14, 8'h18};
	logic [31:0] rstVal [4] = '{32'h12C, 32'h064, 32'h032, 32'h064};
	tls_row_type rows [7] = '{
		'{10'h12C, 10'h064, 1'b0, 10'h3FF, 10'h064},
		'{10'h12C, 10'h064, 1'b1, 10'h3FF, 10'h064},
		'{10'h050, 10'h0C8, 1'b1, 10'h3FF, 10'h050},
		'{10'h050, 10'h0C8, 1'b0, 10'h3FF, 10'h0C8},
		'{10'h12C, 10'h15E, 1'b0, 10'h0FA, 10'h0FA},
		'{10'h190, 10'h190, 1'b1, 10'h3FF, 10'h15E},
		'{10'h000, 10'h15E, 1'b1, 10'h3FF, 10'h000}
	};

	tls_torque_limit_selector #(.MS_CYCLES(MS)) DUT (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .inPins, .outPins, .controlTick, .motorMaxTorque, .torqueCmd, .busVoltage, .mainPowerLost,
		.torqueRef, .fwdLimitEff, .revLimitEff, .undervoltageWarning, .currentLimitActive, .slowBusRamp,
		.motorPowerEnable);
	tls_host_model u_host (.fwdReq, .revReq, .inPins);

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %0t run did not finish", $time);
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		rrsp = s_axi_rresp;
	endtask : rd

	// lets the pin synchroniser settle, then one control cycle
	task automatic pulse_tick();
		repeat (4) @(posedge ref_clk);
		controlTick <= 1'b1;
		@(posedge ref_clk);
		controlTick <= 1'b0;
		@(posedge ref_clk);
	endtask : pulse_tick

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			rd(rstAddr[i]);
			chk(rdat, rstVal[i]);
		end
		rd(8'h80);
		chk({30'h0, rrsp}, {30'h0, `TLS_RESP_SLVERR});
		$display("test reset done");
		wr(8'h28, 32'h333);
		wr(8'h00, 32'h001);
		for (int i = 0; i < 7; i++) begin
			wr(8'h04, {22'h0, rows[i].intLim});
			wr(8'h08, {22'h0, rows[i].intLim});
			wr(8'h0C, {22'h0, rows[i].extLim});
			wr(8'h10, {22'h0, rows[i].extLim});
			fwdReq <= rows[i].pinOn;
			revReq <= rows[i].pinOn;
			motorMaxTorque <= rows[i].maxTq;
			torqueCmd <= $signed({6'h0, rows[i].expLim}) + 16'sh0001;
			pulse_tick();
			chk({22'h0, fwdLimitEff}, {22'h0, rows[i].expLim});
			chk({22'h0, revLimitEff}, {22'h0, rows[i].expLim});
			repeat (3) @(posedge ref_clk);
			chk({29'h0, outPins}, 32'h7);
			chk(32'(torqueRef), {22'h0, rows[i].expLim});
		end
		$display("test rows done");
		wr(8'h04, 32'h12C);
		wr(8'h0C, 32'h15E);
		wr(8'h18, 32'h001);
		wr(8'h00, 32'h003);
		fwdReq <= 1'b1;
		torqueCmd <= 16'sh0000;
		busVoltage <= 12'h100;
		pulse_tick();
		chk({29'h0, undervoltageWarning, currentLimitActive, slowBusRamp}, 32'h7);
		chk({22'h0, fwdLimitEff}, 32'h096);
		busVoltage <= 12'hFFF;
		pulse_tick();
		chk({31'h0, undervoltageWarning}, 32'h0);
		chk({22'h0, fwdLimitEff}, 32'h096);
		repeat (20) @(posedge ref_clk);
		pulse_tick();
		chk({22'h0, fwdLimitEff}, 32'h12C);
		$display("test voltage drop done");
		fwdReq <= 1'b0;
		wr(8'h20, 32'h210);
		wr(8'h24, 32'h003);
		pulse_tick();
		chk({22'h0, fwdLimitEff}, 32'h12C);
		wr(8'h2C, 32'h020);
		pulse_tick();
		chk({22'h0, fwdLimitEff}, 32'h020);
		mainPowerLost <= 1'b1;
		pulse_tick();
		@(posedge ref_clk);
		chk({31'h0, motorPowerEnable}, 32'h1);
		pulse_tick();
		@(posedge ref_clk);
		chk({31'h0, motorPowerEnable}, 32'h0);
		mainPowerLost <= 1'b0;
		torqueCmd <= 16'sh0050;
		wr(8'h00, 32'h005);
		@(posedge ref_clk);
		chk({31'h0, motorPowerEnable}, 32'h1);
		chk(32'(torqueRef), 32'h020);
		wr(8'h00, 32'h000);
		@(posedge ref_clk);
		chk({31'h0, motorPowerEnable}, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk(32'(torqueRef), 32'h0);
		$display("test power hold done");
		give_verdict();
	end
endmodule : tb

`default_nettype wire
